//--- verilog/acs_sequencer.v
// acs_sequencer.v: conversion sequencer with its AXI4-Lite register file
//
// Summary of operation
// - continuous mode loops over enabled channels, then diagnostics
// - stop command takes effect after current sequence
// - sequence end copies results to result registers
// - fixed input-select codes for five mux paths
// - out-of-range flags error, alerts, forces code
// - masked range error leaves alert deasserted
// - results are 24-bit offset binary codes
// - buffers full power until standby bit set
// - diagnostics run whatever the buffer power state
// - per-channel rate, one shared diagnostic rate
// - fixed set of channel and diagnostic rates
// - hum and modem tone rejecting rate codes
// - conversion timing from internal clock, not host
// - power-up, pipeline delay, then conversion time
// - lone continuous channel adds no switch time
// - switch delay added on each input change
// - source current diagnostic adds 41 us
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_sequencer #(
    parameter [27:0] TIME_STEP_NS = `ACS_CLK_NS
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire [23:0] adc_data_i,
    input wire adc_over_i,
    input wire adc_under_i,
    output wire adc_power_o,
    output wire [2:0] mux_index_o,
    output wire [2:0] input_select_o,
    output wire [3:0] channel_rate_field_o,
    output wire conv_start_o,
    output wire conv_end_o,
    output wire seq_done_o,
    output wire [15:0] buffer_standby_o,
    output wire alert_o
);
    // ======================================================================
    // states
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_PWRUP = 6'h02;
    localparam [5:0] ST_PIPE = 6'h04;
    localparam [5:0] ST_SWITCH = 6'h08;
    localparam [5:0] ST_CONV = 6'h10;
    localparam [5:0] ST_DONE = 6'h20;

    // ======================================================================
    // registers and state
    reg [16:0] ctrl_r;
    reg [6:0] cfg_r [0:3];
    reg [15:0] bpwr_r;
    reg amsk_r;
    reg aerr_r;
    reg rdy_r;
    reg [1:0] cnt_r;
    reg pwr_r;
    reg [23:0] shd_r [0:7];
    reg [23:0] res_r [0:7];
    reg [5:0] state_r;
    reg [5:0] state_nxt;
    reg [2:0] idx_r;
    reg ld_r;
    reg [27:0] tmr_r;
    reg [27:0] load_val;
    reg [2:0] sel_r;
    reg [3:0] rate_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [1:0] rresp_r;
    reg [31:0] rdata_r;
    reg [2:0] first_idx;
    reg [2:0] next_idx;
    reg has_next;
    reg [3:0] n_en;
    integer i;

    wire [1:0] cmd = ctrl_r[`ACS_F_CMD +: 2];
    wire [7:0] en = {ctrl_r[`ACS_F_DGEN +: 4], ctrl_r[`ACS_F_CHEN +: 4]};
    wire [3:0] dsrc = ctrl_r[`ACS_F_DSRC +: 4];
    wire busy = (state_r != ST_IDLE);
    wire start_go = ((cmd == `ACS_CMD_SINGLE) || (cmd == `ACS_CMD_CONT)) && (|en);
    wire [3:0] cur_rate = idx_r[2] ? {1'b0, ctrl_r[`ACS_F_DRATE +: 3]} : cfg_r[idx_r[1:0]][6:3];
    wire [27:0] pipe_ns;
    wire [27:0] conv_ns;
    wire [27:0] switch_ns;
    wire [23:0] clamp_code;
    wire clamp_err;
    wire tmr_exp = ~ld_r & (tmr_r <= TIME_STEP_NS);
    wire conv_end = (state_r == ST_CONV) & tmr_exp;

    // ======================================================================
    // timing lookup and range handling
    acs_rate_table u_rate_table (
        .rate_i(cur_rate),
        .diag_i(idx_r[2]),
        .src_i(dsrc[idx_r[1:0]]),
        .pipe_ns_o(pipe_ns),
        .conv_ns_o(conv_ns),
        .switch_ns_o(switch_ns)
    );

    acs_range_clamp u_range_clamp (
        .data_i(adc_data_i),
        .over_i(adc_over_i),
        .under_i(adc_under_i),
        .code_o(clamp_code),
        .err_o(clamp_err)
    );

    // ======================================================================
    // input search: channels first, then diagnostics
    always @* begin
        first_idx = 3'h0;
        next_idx = 3'h0;
        has_next = 1'b0;
        n_en = 4'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            if (en[i]) begin
                first_idx = i[2:0];
                n_en = n_en + 4'h1;
                if (i > idx_r) begin
                    next_idx = i[2:0];
                    has_next = 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // sequence state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_go) begin
                    state_nxt = pwr_r ? ST_PIPE : ST_PWRUP;
                end
            end
            ST_PWRUP: begin
                if (tmr_exp) begin
                    state_nxt = ST_PIPE;
                end
            end
            ST_PIPE: begin
                if (tmr_exp) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (tmr_exp) begin
                    state_nxt = has_next ? ST_SWITCH : ST_DONE;
                end
            end
            ST_SWITCH: begin
                if (tmr_exp) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_DONE: begin
                if (cmd == `ACS_CMD_CONT && (|en)) begin
                    state_nxt = (n_en > 4'h1) ? ST_SWITCH : ST_CONV;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // phase time of the state being entered; clock_i is the internal oscillator
    always @* begin
        case (state_r)
            ST_PWRUP: load_val = `ACS_US_100;
            ST_PIPE: load_val = pipe_ns;
            ST_SWITCH: load_val = switch_ns;
            ST_CONV: load_val = conv_ns;
            default: load_val = TIME_STEP_NS;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            ld_r <= 1'b0;
            tmr_r <= 28'h0000000;
            idx_r <= 3'h0;
            sel_r <= `ACS_SEL_TERM_GND;
            rate_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            ld_r <= (state_nxt != state_r);
            if (ld_r) begin
                tmr_r <= load_val;
            end else if (!tmr_exp) begin
                tmr_r <= tmr_r - TIME_STEP_NS;
            end
            if ((state_r == ST_IDLE && start_go) || state_r == ST_DONE) begin
                idx_r <= first_idx;
            end else if (conv_end && has_next) begin
                idx_r <= next_idx;
            end
            // diagnostics take the ground path and ignore buffer standby
            sel_r <= idx_r[2] ? `ACS_SEL_GND_GND : cfg_r[idx_r[1:0]][2:0];
            rate_r <= cur_rate;
        end
    end

    // ======================================================================
    // register bus
    wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_r;
    wire rd_go = s_axi_arvalid_i & ~rvalid_r;
    wire [32:0] wold = acs_read(s_axi_awaddr_i);
    wire [32:0] rnow = acs_read(s_axi_araddr_i);
    wire [31:0] wm = acs_merge(wold[31:0], s_axi_wdata_i, s_axi_wstrb_i);
    wire [3:0] wpg = s_axi_awaddr_i[7:4];
    wire [1:0] wk = s_axi_awaddr_i[3:2];

    // bit 32 marks a mapped address
    function [32:0] acs_read;
        input [7:0] a;
        begin
            acs_read = {1'b1, 32'h00000000};
            case (a[7:4])
                4'h0: begin
                    case ({a[7:2], 2'b00})
                        `ACS_ADDR_CTRL: acs_read[31:0] = {15'h0000, ctrl_r};
                        `ACS_ADDR_STAT: acs_read[31:0] = {27'h0000000, cnt_r, rdy_r, pwr_r, busy};
                        `ACS_ADDR_ALST: acs_read[31:0] = {31'h00000000, aerr_r};
                        default: acs_read[31:0] = {31'h00000000, amsk_r};
                    endcase
                end
                4'h1: begin
                    acs_read[31:0] = {16'h0000, bpwr_r};
                    acs_read[32] = ({a[7:2], 2'b00} == `ACS_ADDR_BPWR);
                end
                `ACS_PG_CFG: acs_read[31:0] = {25'h0000000, cfg_r[a[3:2]]};
                `ACS_PG_RLO: acs_read[31:0] = {16'h0000, res_r[{1'b0, a[3:2]}][15:0]};
                `ACS_PG_RHI: acs_read[31:0] = {24'h000000, res_r[{1'b0, a[3:2]}][23:16]};
                `ACS_PG_DRES: acs_read[31:0] = {8'h00, res_r[{1'b1, a[3:2]}]};
                default: acs_read[32] = 1'b0;
            endcase
        end
    endfunction

    function [31:0] acs_merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer b;
        begin
            acs_merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (s[b]) begin
                    acs_merge[b * 8 +: 8] = d[b * 8 +: 8];
                end
            end
        end
    endfunction

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rresp_r <= 2'b00;
            rdata_r <= 32'h00000000;
        end else begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wold[32] ? 2'b00 : 2'b10;
            end else if (s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rresp_r <= rnow[32] ? 2'b00 : 2'b10;
                rdata_r <= rnow[31:0];
            end else if (s_axi_rready_i) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // register file and result transfer
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= 17'h00000;
            bpwr_r <= 16'h0000;
            amsk_r <= 1'b0;
            aerr_r <= 1'b0;
            rdy_r <= 1'b0;
            cnt_r <= 2'h0;
            pwr_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                cfg_r[i] <= `ACS_CFG_RST;
            end
            for (i = 0; i < 8; i = i + 1) begin
                shd_r[i] <= 24'h000000;
                res_r[i] <= 24'h000000;
            end
        end else begin
            if (state_r == ST_IDLE && start_go) begin
                pwr_r <= 1'b1;
            end else if (state_r == ST_IDLE && cmd == `ACS_CMD_PDOWN) begin
                pwr_r <= 1'b0;
            end
            if (state_r == ST_DONE && cmd == `ACS_CMD_SINGLE) begin
                ctrl_r[`ACS_F_CMD +: 2] <= `ACS_CMD_IDLE;
            end
            if (wr_go && wold[32]) begin
                case (wpg)
                    4'h0: begin
                        case (wk)
                            2'h0: ctrl_r <= wm[16:0];
                            2'h1: begin
                                if (wm[2]) begin
                                    rdy_r <= 1'b0;
                                end
                            end
                            2'h2: begin
                                if (wm[0]) begin
                                    aerr_r <= 1'b0;
                                end
                            end
                            default: amsk_r <= wm[0];
                        endcase
                    end
                    4'h1: begin
                        if (!busy) begin
                            bpwr_r <= wm[15:0];
                        end
                    end
                    `ACS_PG_CFG: cfg_r[wk] <= wm[6:0];
                    default: begin
                    end
                endcase
            end
            if (conv_end) begin
                shd_r[idx_r] <= clamp_code;
                if (clamp_err) begin
                    aerr_r <= 1'b1;
                end
            end
            if (state_r == ST_DONE) begin
                for (i = 0; i < 8; i = i + 1) begin
                    res_r[i] <= shd_r[i];
                end
                rdy_r <= 1'b1;
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end

    // ======================================================================
    // outputs
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = ~rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rresp_o = rresp_r;
    assign s_axi_rdata_o = rdata_r;
    assign adc_power_o = pwr_r;
    assign mux_index_o = idx_r;
    assign input_select_o = sel_r;
    assign channel_rate_field_o = rate_r;
    assign conv_start_o = (state_r == ST_CONV) & ld_r;
    assign conv_end_o = conv_end;
    assign seq_done_o = (state_r == ST_DONE);
    assign buffer_standby_o = bpwr_r;
    assign alert_o = aerr_r & ~amsk_r;
endmodule // acs_sequencer

//--- verilog/acs_defines.vh
// acs_defines.vh: register map, fields, codes and times of the sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// ==========================================================================
// register map and per-input register pages
`define ACS_ADDR_CTRL 8'h00
`define ACS_ADDR_STAT 8'h04
`define ACS_ADDR_ALST 8'h08
`define ACS_ADDR_AMSK 8'h0c
`define ACS_ADDR_BPWR 8'h10
`define ACS_PG_CFG 4'h2
`define ACS_PG_RLO 4'h3
`define ACS_PG_RHI 4'h4
`define ACS_PG_DRES 4'h5
// ==========================================================================
// field positions of conversion_control_reg
`define ACS_F_CMD 0
`define ACS_F_CHEN 2
`define ACS_F_DGEN 6
`define ACS_F_DRATE 10
`define ACS_F_DSRC 13
// channel_measure_config: input_select_field [2:0], channel_rate_field [6:3]
`define ACS_F_RATE 3
`define ACS_CFG_RST {`ACS_RATE_20, `ACS_SEL_TERM_GND}
// ==========================================================================
// sequence_command_field codes
`define ACS_CMD_IDLE 2'h0
`define ACS_CMD_SINGLE 2'h1
`define ACS_CMD_CONT 2'h2
`define ACS_CMD_PDOWN 2'h3
// input_select_field codes
`define ACS_SEL_TERM_GND 3'h0
`define ACS_SEL_SHUNT_TERM 3'h1
`define ACS_SEL_AUXN_GND 3'h2
`define ACS_SEL_TERM_AUXN 3'h3
`define ACS_SEL_GND_GND 3'h4
// channel_rate_field codes
`define ACS_RATE_10H 4'h0
`define ACS_RATE_20 4'h1
`define ACS_RATE_20H 4'h3
`define ACS_RATE_200HM 4'h4
`define ACS_RATE_200H 4'h6
`define ACS_RATE_1K2 4'h8
`define ACS_RATE_1K2H 4'h9
`define ACS_RATE_4K8 4'hc
`define ACS_RATE_9K6 4'hd
// diagnostic rate codes
`define ACS_DRATE_20 3'h0
`define ACS_DRATE_20H 3'h1
`define ACS_DRATE_1K2H 3'h2
`define ACS_DRATE_4K8 3'h3
`define ACS_DRATE_9K6 3'h4
`define ACS_DRATE_19K2 3'h5
// result codes
`define ACS_CODE_OVER 24'h0fffff
`define ACS_CODE_UNDER 24'h000000
// ==========================================================================
// times in ns; the timer subtracts the clock period each cycle
`define ACS_CLK_NS 28'd40
`define ACS_US_13 28'd13000
`define ACS_US_40 28'd40000
`define ACS_US_41 28'd41000
`define ACS_US_67 28'd67000
`define ACS_US_68 28'd68000
`define ACS_US_69 28'd69000
`define ACS_US_100 28'd100000
`define ACS_US_124 28'd124000
`define ACS_US_331 28'd331000
`define ACS_US_386 28'd386000
`define ACS_US_950 28'd950000
`define ACS_US_1000 28'd1000000
`define ACS_US_1685 28'd1685000
`define ACS_US_1740 28'd1740000
`define ACS_US_2519 28'd2519000
`define ACS_US_2574 28'd2574000
`define ACS_US_5000 28'd5000000
`define ACS_US_5024 28'd5024000
`define ACS_US_52_08 28'd52080
`define ACS_US_104_17 28'd104170
`define ACS_US_208_33 28'd208330
`define ACS_US_833 28'd833000
`define ACS_US_833_33 28'd833330
`define ACS_MS_4_583 28'd4583000
`define ACS_MS_5 28'd5000000
`define ACS_MS_48_33 28'd48330000
`define ACS_MS_50 28'd50000000
`define ACS_MS_100 28'd100000000
`endif

//--- verilog/acs_rate_table.v
// acs_rate_table.v: pipeline, conversion and switch times per rate code
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_rate_table (
    input wire [3:0] rate_i,
    input wire diag_i,
    input wire src_i,
    output reg [27:0] pipe_ns_o,
    output reg [27:0] conv_ns_o,
    output reg [27:0] switch_ns_o
);
    always @* begin
        if (diag_i) begin
            case (rate_i[2:0]) // one rate for all diagnostics
                `ACS_DRATE_20H: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_1740, `ACS_MS_48_33, `ACS_US_1685};
                `ACS_DRATE_1K2H: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_124, `ACS_US_833, `ACS_US_69};
                `ACS_DRATE_4K8: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_68, `ACS_US_208_33, `ACS_US_13};
                `ACS_DRATE_9K6: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_40, `ACS_US_104_17, `ACS_US_13};
                `ACS_DRATE_19K2: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_40, `ACS_US_52_08, `ACS_US_13};
                default: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_67, `ACS_MS_50, `ACS_US_100};
            endcase
            if (src_i) begin
                conv_ns_o = conv_ns_o + `ACS_US_41;
            end
        end else begin
            case (rate_i)
                `ACS_RATE_10H: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_5000, `ACS_MS_100, `ACS_US_5024};
                `ACS_RATE_20H: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_2574, `ACS_MS_50, `ACS_US_2519};
                `ACS_RATE_200HM: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_1000, `ACS_MS_5, `ACS_US_950};
                `ACS_RATE_200H: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_386, `ACS_MS_4_583, `ACS_US_331};
                `ACS_RATE_1K2: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_67, `ACS_US_833_33, `ACS_US_13};
                `ACS_RATE_1K2H: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_124, `ACS_US_833, `ACS_US_69};
                `ACS_RATE_4K8: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_68, `ACS_US_208_33, `ACS_US_13};
                `ACS_RATE_9K6: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_40, `ACS_US_104_17, `ACS_US_13};
                default: {pipe_ns_o, conv_ns_o, switch_ns_o} = {`ACS_US_67, `ACS_MS_50, `ACS_US_100};
            endcase
        end
    end
endmodule // acs_rate_table

//--- verilog/acs_range_clamp.v
// acs_range_clamp.v: forces the result code on an out-of-range conversion
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_range_clamp (
    input wire [23:0] data_i,
    input wire over_i,
    input wire under_i,
    output wire [23:0] code_o,
    output wire err_o
);
    // offset binary straight from the modulator
    assign code_o = over_i ? `ACS_CODE_OVER : (under_i ? `ACS_CODE_UNDER : data_i);
    assign err_o = over_i | under_i;
endmodule // acs_range_clamp

//--- bench/acs_sequencer_checker.sv
// acs_sequencer_checker.sv: concurrent checks on the sequencer ports
`timescale 1ns/1ps
module acs_sequencer_checker (
    input wire clock_i,
    input wire rst_n_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_wvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wready_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire s_axi_rvalid_o,
    input wire [2:0] mux_index_o,
    input wire [2:0] input_select_o,
    input wire conv_start_o,
    input wire conv_end_o,
    input wire seq_done_o,
    input wire adc_power_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================================
    // conversion: start pulse, then end pulse
    sequence s_conv;
        conv_start_o ##[1:4] conv_end_o;
    endsequence
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o |=> s_axi_bvalid_o)
        else $error("write response missing");
    a_bvalid_cause: assert property ($rose(s_axi_bvalid_o) |-> $past(s_axi_awvalid_i && s_axi_wvalid_i))
        else $error("write response without request");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response missing");
    a_arready_rule: assert property (s_axi_arready_o == !s_axi_rvalid_o)
        else $error("arready wrong");
    a_ready_pair: assert property (s_axi_awready_o == (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o)
        && s_axi_wready_o == s_axi_awready_o) else $error("write ready wrong");
    a_conv_length: assert property (conv_start_o |-> s_conv)
        else $error("conversion did not end");
    a_done_follows: assert property (seq_done_o |-> $past(conv_end_o))
        else $error("transfer not after last conversion");
    a_diag_select: assert property (conv_start_o && mux_index_o[2] |-> input_select_o == 3'h4)
        else $error("diagnostic select wrong");
    a_power_conv: assert property (conv_start_o |-> adc_power_o)
        else $error("conversion while unpowered");
endmodule // acs_sequencer_checker
bind acs_sequencer acs_sequencer_checker acs_sequencer_checker_inst (.*);

//--- bench/acs_adc_model.sv
// acs_adc_model.sv: behavioural modulator answering each conversion
`timescale 1ns/1ps
module acs_adc_model (
    input wire clock_i,
    input wire rst_n_i,
    input wire [2:0] mux_index_i,
    input wire conv_start_i,
    input wire conv_end_i,
    input wire force_over_i,
    input wire force_under_i,
    output reg [23:0] data_o,
    output wire over_o,
    output wire under_o
);
    reg act_r;
    // code names its input; outside a conversion the data toggles
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_r <= 1'b0;
            data_o <= 24'h0;
        end else if (conv_start_i) begin
            act_r <= 1'b1;
            data_o <= {5'h15, mux_index_i, 16'h3c5a};
        end else if (conv_end_i) begin
            act_r <= 1'b0;
        end else if (!act_r) begin
            data_o <= ~data_o;
        end
    end
    assign over_o = act_r && force_over_i && mux_index_i == 3'h1;
    assign under_o = act_r && force_under_i && mux_index_i == 3'h2;
endmodule // acs_adc_model

//--- bench/tb_adc_conversion_sequencer.sv
// tb_adc_conversion_sequencer.sv: self-checking bench of the sequencer
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
    logic clock_i = 0, rst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, force_over_i = 0, force_under_i = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, rdv;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic [1:0] resp;
    logic [6:0] exp_cfg [0:3] = '{7'h08, 7'h08, 7'h08, 7'h08};
    wire [31:0] s_axi_rdata_o;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire [23:0] adc_data_i;
    wire adc_over_i, adc_under_i, adc_power_o, conv_start_o, conv_end_o, seq_done_o, alert_o;
    wire [2:0] mux_index_o, input_select_o;
    wire [3:0] channel_rate_field_o;
    wire [15:0] buffer_standby_o;
    int errors = 0, n_checks = 0, n_done = 0, n_start = 0;
    always #20 clock_i = ~clock_i;
    acs_sequencer #(.TIME_STEP_NS(28'd100000000)) acs_sequencer_inst (.*);
    acs_adc_model acs_adc_model_inst (.clock_i, .rst_n_i, .mux_index_i(mux_index_o), .conv_start_i(conv_start_o),
        .conv_end_i(conv_end_o), .force_over_i, .force_under_i, .data_o(adc_data_i), .over_o(adc_over_i),
        .under_o(adc_under_i));
    // ==========================================================================
    // bus tasks and compare
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clock_i);
        {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        do @(negedge clock_i); while (s_axi_awready_o !== 1'b1);
        @(posedge clock_i);
        {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'h0;
        do @(negedge clock_i); while (s_axi_bvalid_o !== 1'b1);
        resp = s_axi_bresp_o;
        @(posedge clock_i);
        s_axi_bready_i <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge clock_i);
        {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
        do @(negedge clock_i); while (s_axi_arready_o !== 1'b1);
        @(posedge clock_i);
        s_axi_arvalid_i <= 0;
        do @(negedge clock_i); while (s_axi_rvalid_o !== 1'b1);
        {rdv, resp} = {s_axi_rdata_o, s_axi_rresp_o};
        @(posedge clock_i);
        s_axi_rready_i <= 0;
    endtask
    task wait_done;
        int d0;
        d0 = n_done;
        repeat (300) if (n_done == d0) @(posedge clock_i);
        chk("sequence end", n_done != d0, 1);
    endtask
    always @(posedge clock_i) begin
        n_done += seq_done_o;
        n_start += conv_start_o;
        if (conv_start_o === 1'b1)
            chk("rate and select", {channel_rate_field_o, input_select_o},
                mux_index_o[2] ? 7'h2c : exp_cfg[mux_index_o[1:0]]);
    end
    // ==========================================================================
    // scenarios
    task t_regs;
        rd(8'h20);
        chk("cfg reset", rdv, 32'h08);
        rd(8'h10);
        chk("buffer power reset", rdv, 0);
        chk("standby pins", buffer_standby_o, 0);
        rd(8'hfc);
        chk("unmapped read", resp, 2'b10);
        wr(8'hf8, 32'h1);
        chk("unmapped write", resp, 2'b10);
    endtask
    task t_single;
        for (int n = 0; n < 4; n++) begin
            exp_cfg[n] = {4'hc, n[2:0]};
            wr(8'h20 + 8'(4 * n), {25'h0, exp_cfg[n]});
        end
        wr(8'h00, 32'h347d);
        wait_done;
        for (int n = 0; n < 4; n++) begin
            rd(8'h30 + 8'(4 * n));
            chk("result low", rdv, 32'h3c5a);
            rd(8'h40 + 8'(4 * n));
            chk("result high", rdv & 32'hff, 32'ha8 + n);
        end
        rd(8'h50);
        chk("diag result", rdv, 32'hac3c5a);
        rd(8'h00);
        chk("single reverts idle", rdv & 32'h3, 0);
    endtask
    task t_range;
        {force_over_i, force_under_i} <= 2'h3;
        exp_cfg[0] = 7'h64;
        wr(8'h20, 32'h64);
        wr(8'h00, 32'h1d);
        wait_done;
        rd(8'h34);
        chk("over low", rdv, 32'hffff);
        rd(8'h44);
        chk("over high", rdv & 32'hff, 32'h0f);
        rd(8'h38);
        chk("under low", rdv, 0);
        rd(8'h08);
        chk("range flag", rdv & 32'h1, 1);
        chk("alert on", alert_o, 1);
        wr(8'h0c, 32'h1);
        chk("alert masked", alert_o, 0);
        wr(8'h0c, 32'h0);
        chk("alert unmasked", alert_o, 1);
        wr(8'h08, 32'h1);
        chk("alert cleared", alert_o, 0);
        {force_over_i, force_under_i} <= 2'h0;
    endtask
    task t_cont;
        int d0, s0;
        wr(8'h00, 32'h0e);
        wait_done;
        wait_done;
        d0 = n_done;
        wr(8'h00, 32'h0);
        repeat (60) @(posedge clock_i);
        chk("stop at sequence end", n_done - d0, 1);
        s0 = n_start;
        repeat (30) @(posedge clock_i);
        chk("halted", n_start - s0, 0);
        rd(8'h04);
        chk("not busy", rdv & 32'h1, 0);
    endtask
    task t_buf;
        wr(8'h10, 32'hf);
        chk("standby set", buffer_standby_o, 16'hf);
        wr(8'h00, 32'h1441);
        wr(8'h10, 32'h0);
        chk("busy write ignored", buffer_standby_o, 16'hf);
        wait_done;
        rd(8'h50);
        chk("diag in standby", rdv, 32'hac3c5a);
        wr(8'h10, 32'h0);
        chk("standby cleared", buffer_standby_o, 0);
    endtask
    task complete_run;
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1;
        t_regs;
        t_single;
        t_range;
        t_cont;
        t_buf;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        complete_run;
    end
endmodule // tb_adc_conversion_sequencer
